// [design/mux_table_if.sv]
`timescale 1ns/1ps

// Carries override writes into the table and the table contents back out.
interface mux_table_if;
	logic                                   write_en;
	logic [pin_mux_pkg::PIN_NUM_W-1:0]      write_index;
	logic                                   write_override;
	pin_mux_pkg::func_t                     write_func;
	logic [pin_mux_pkg::PIN_NUM_W-1:0]      read_index;
	pin_mux_pkg::func_t                     read_func;
	logic                                   read_override;
	logic [pin_mux_pkg::NUM_PINS-1:0]       override_valid;
	pin_mux_pkg::func_t                     override_func [pin_mux_pkg::NUM_PINS];

	modport table_side (
		input  write_en, write_index, write_override, write_func, read_index,
		output read_func, read_override, override_valid, override_func
	);
	modport user_side (
		output write_en, write_index, write_override, write_func, read_index,
		input  read_func, read_override, override_valid, override_func
	);
endinterface

// [design/pin_mux_pkg.sv]
package pin_mux_pkg;

	// Bank geometry: pin numbers 3 to 31, held at indices 0 to 28.
	localparam int NUM_PINS  = 29;
	localparam int FIRST_PIN = 3;
	localparam int LAST_PIN  = 31;
	localparam int PIN_NUM_W = 5;

	// Function codes and the width of the per-function vectors.
	localparam int FUNC_W   = 5;
	localparam int NUM_FUNC = 27;

	// Resistor level that the strap front end reports for each strap.
	localparam int LEVEL_W = 3;
	localparam logic [LEVEL_W-1:0] LEVEL_PD_200K = 3'h0;
	localparam logic [LEVEL_W-1:0] LEVEL_PU_200K = 3'h1;
	localparam logic [LEVEL_W-1:0] LEVEL_PD_10K  = 3'h2;
	localparam logic [LEVEL_W-1:0] LEVEL_PU_10K  = 3'h3;
	localparam logic [LEVEL_W-1:0] LEVEL_PD_10R  = 3'h4;
	localparam logic [LEVEL_W-1:0] LEVEL_PU_10R  = 3'h5;

	// Enabled cycles after reset release before the straps are sampled.
	localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

	// Values after reset.
	localparam logic [NUM_PINS-1:0] PINS_RESET     = 29'h0000_0000;
	localparam logic [NUM_FUNC-1:0] FUNCS_RESET    = 27'h000_0000;
	localparam logic [LEVEL_W-1:0]  LEVEL_RESET    = 3'h0;
	localparam logic                OVERRIDE_RESET = 1'b0;

	// Latched strap mode; Gray codes along wait, then a decoded mode.
	typedef enum logic [1:0] {
		MODE_WAIT     = 2'b00,
		MODE_RESERVED = 2'b10,
		MODE_CONFIG3  = 2'b01
	} mode_t;

	// Pin functions; the code also indexes the per-function vectors.
	typedef enum logic [FUNC_W-1:0] {
		FUNC_NONE                   = 5'h00,
		FUNC_AUDIO_SERIAL_IN        = 5'h01,
		FUNC_AUDIO_SERIAL_OUT       = 5'h02,
		FUNC_AUDIO_BIT_CLOCK        = 5'h03,
		FUNC_AUDIO_WORD_SELECT      = 5'h04,
		FUNC_AUDIO_MASTER_CLOCK     = 5'h05,
		FUNC_PORT1_POWER_CONTROL    = 5'h06,
		FUNC_PORT2_POWER_CONTROL    = 5'h07,
		FUNC_PORT3_POWER_CONTROL    = 5'h08,
		FUNC_PORT4_POWER_CONTROL    = 5'h09,
		FUNC_PORT5_POWER_CONTROL    = 5'h0A,
		FUNC_PORT6_POWER_CONTROL    = 5'h0B,
		FUNC_PORT3_SUPERSPEED_POWER = 5'h0C,
		FUNC_PORT4_SUPERSPEED_POWER = 5'h0D,
		FUNC_PORT5_SUPERSPEED_POWER = 5'h0E,
		FUNC_BRIDGE_MASTER_CLOCK    = 5'h0F,
		FUNC_BRIDGE_MASTER_LINE     = 5'h10,
		FUNC_MICROPHONE_SENSE       = 5'h11,
		FUNC_FLASH_SELECT_N         = 5'h12,
		FUNC_FLASH_CLOCK            = 5'h13,
		FUNC_FLASH_IO0              = 5'h14,
		FUNC_FLASH_IO1              = 5'h15,
		FUNC_FLASH_IO2              = 5'h16,
		FUNC_FLASH_IO3              = 5'h17,
		FUNC_TARGET_SERIAL_CLOCK    = 5'h18,
		FUNC_TARGET_SERIAL_LINE     = 5'h19,
		FUNC_UPSTREAM_POWER_SENSE   = 5'h1A
	} func_t;

endpackage

// [design/pin_override_table.sv]
`timescale 1ns/1ps

module pin_override_table (
	input  wire logic        i_clock,
	input  wire logic        i_resetn,
	input  wire logic        i_clock_enable,
	mux_table_if.table_side  bus
);

	logic                 valid_q [pin_mux_pkg::NUM_PINS];
	logic                 valid_d [pin_mux_pkg::NUM_PINS];
	pin_mux_pkg::func_t   func_q  [pin_mux_pkg::NUM_PINS];
	pin_mux_pkg::func_t   func_d  [pin_mux_pkg::NUM_PINS];
	pin_mux_pkg::func_t   read_func_q;
	pin_mux_pkg::func_t   read_func_d;
	logic                 read_override_q;
	logic                 read_override_d;

	// One entry changes per write; every other entry keeps its value.
	always_comb begin
		valid_d         = valid_q;
		func_d          = func_q;
		read_func_d     = pin_mux_pkg::FUNC_NONE;
		read_override_d = pin_mux_pkg::OVERRIDE_RESET;
		if (bus.write_en && bus.write_index < pin_mux_pkg::NUM_PINS) begin
			valid_d[bus.write_index] = bus.write_override;
			func_d[bus.write_index]  = bus.write_func;
		end
		if (bus.read_index < pin_mux_pkg::NUM_PINS) begin
			read_func_d     = func_q[bus.read_index];
			read_override_d = valid_q[bus.read_index];
		end
	end

	// Table and registered read port.
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int i = 0; i < pin_mux_pkg::NUM_PINS; i++) begin
				valid_q[i] <= pin_mux_pkg::OVERRIDE_RESET;
				func_q[i]  <= pin_mux_pkg::FUNC_NONE;
			end
			read_func_q     <= pin_mux_pkg::FUNC_NONE;
			read_override_q <= pin_mux_pkg::OVERRIDE_RESET;
		end else if (i_clock_enable) begin
			valid_q         <= valid_d;
			func_q          <= func_d;
			read_func_q     <= read_func_d;
			read_override_q <= read_override_d;
		end
	end

	// Table contents feed the mux directly.
	always_comb begin
		for (int i = 0; i < pin_mux_pkg::NUM_PINS; i++) begin
			bus.override_valid[i] = valid_q[i];
			bus.override_func[i]  = func_q[i];
		end
	end

	assign bus.read_func     = read_func_q;
	assign bus.read_override = read_override_q;

endmodule // pin_override_table

// [design/strap_mode_latch.sv]
`timescale 1ns/1ps

module strap_mode_latch (
	input  wire logic                              i_clock,
	input  wire logic                              i_resetn,
	input  wire logic                              i_clock_enable,
	input  wire logic [pin_mux_pkg::LEVEL_W-1:0]   i_strap1_level,
	input  wire logic [pin_mux_pkg::LEVEL_W-1:0]   i_strap2_level,
	output pin_mux_pkg::mode_t                     o_mode
);

	logic [pin_mux_pkg::LEVEL_W-1:0] strap1_meta_q;
	logic [pin_mux_pkg::LEVEL_W-1:0] strap1_q;
	logic [pin_mux_pkg::LEVEL_W-1:0] strap2_meta_q;
	logic [pin_mux_pkg::LEVEL_W-1:0] strap2_q;
	logic [1:0]                      settle_q;
	logic [1:0]                      settle_d;
	pin_mux_pkg::mode_t              mode_q;
	pin_mux_pkg::mode_t              mode_d;

	// Waits for the synchronisers to fill, then latches the mode once and holds it.
	always_comb begin
		settle_d = settle_q;
		mode_d   = mode_q;
		if (mode_q == pin_mux_pkg::MODE_WAIT) begin
			if (settle_q == pin_mux_pkg::STRAP_SETTLE_CYCLES) begin
				// Only one strap pair is decoded; the spare strap is never looked at.
				if (strap2_q == pin_mux_pkg::LEVEL_PD_200K &&
				    strap1_q == pin_mux_pkg::LEVEL_PD_10K) begin
					mode_d = pin_mux_pkg::MODE_CONFIG3;
				end else begin
					mode_d = pin_mux_pkg::MODE_RESERVED;
				end
			end else begin
				settle_d = settle_q + 2'h1;
			end
		end
	end

	// Strap levels cross in through two flops before the decode reads them.
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			strap1_meta_q <= pin_mux_pkg::LEVEL_RESET;
			strap1_q      <= pin_mux_pkg::LEVEL_RESET;
			strap2_meta_q <= pin_mux_pkg::LEVEL_RESET;
			strap2_q      <= pin_mux_pkg::LEVEL_RESET;
			settle_q      <= 2'h0;
			mode_q        <= pin_mux_pkg::MODE_WAIT;
		end else if (i_clock_enable) begin
			strap1_meta_q <= i_strap1_level;
			strap1_q      <= strap1_meta_q;
			strap2_meta_q <= i_strap2_level;
			strap2_q      <= strap2_meta_q;
			settle_q      <= settle_d;
			mode_q        <= mode_d;
		end
	end

	assign o_mode = mode_q;

endmodule // strap_mode_latch

// [design/strap_selected_pin_function_mux.sv]
`timescale 1ns/1ps

module strap_selected_pin_function_mux (
	input  wire logic                                  i_clock,
	input  wire logic                                  i_resetn,
	input  wire logic                                  i_clock_enable,
	input  wire logic [pin_mux_pkg::LEVEL_W-1:0]       i_mode_strap1_level,
	input  wire logic [pin_mux_pkg::LEVEL_W-1:0]       i_mode_strap2_level,
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0]      i_programmable_pins,
	output logic      [pin_mux_pkg::NUM_PINS-1:0]      o_programmable_pins,
	output logic      [pin_mux_pkg::NUM_PINS-1:0]      o_programmable_pins_oe,
	input  wire logic [pin_mux_pkg::NUM_FUNC-1:0]      i_function_out,
	input  wire logic [pin_mux_pkg::NUM_FUNC-1:0]      i_function_oe,
	output logic      [pin_mux_pkg::NUM_FUNC-1:0]      o_function_in,
	input  wire logic                                  i_select_write,
	input  wire logic [pin_mux_pkg::PIN_NUM_W-1:0]     i_select_pin,
	input  wire logic                                  i_select_override,
	input  wire logic [pin_mux_pkg::FUNC_W-1:0]        i_select_function,
	input  wire logic [pin_mux_pkg::PIN_NUM_W-1:0]     i_readback_pin,
	output logic      [pin_mux_pkg::FUNC_W-1:0]        o_readback_function,
	output logic                                       o_readback_override,
	output logic                                       o_mode_captured,
	output logic                                       o_mode_config3,
	output logic                                       o_microphone_present,
	output logic                                       o_upstream_power_present
);

	// Default function of a pin number in the latched mode.
	function automatic pin_mux_pkg::func_t default_function(input int pin,
	                                                        input pin_mux_pkg::mode_t mode);
		pin_mux_pkg::func_t f;
		f = pin_mux_pkg::FUNC_NONE;
		if (mode == pin_mux_pkg::MODE_CONFIG3) begin
			case (pin)
				3: f = pin_mux_pkg::FUNC_AUDIO_SERIAL_IN;
				4: f = pin_mux_pkg::FUNC_AUDIO_SERIAL_OUT;
				5: f = pin_mux_pkg::FUNC_AUDIO_BIT_CLOCK;
				6: f = pin_mux_pkg::FUNC_AUDIO_WORD_SELECT;
				7: f = pin_mux_pkg::FUNC_AUDIO_MASTER_CLOCK;
				10: f = pin_mux_pkg::FUNC_PORT3_SUPERSPEED_POWER;
				11: f = pin_mux_pkg::FUNC_PORT4_SUPERSPEED_POWER;
				12: f = pin_mux_pkg::FUNC_PORT5_SUPERSPEED_POWER;
				13: f = pin_mux_pkg::FUNC_PORT5_POWER_CONTROL;
				14: f = pin_mux_pkg::FUNC_PORT4_POWER_CONTROL;
				15: f = pin_mux_pkg::FUNC_PORT3_POWER_CONTROL;
				16: f = pin_mux_pkg::FUNC_PORT2_POWER_CONTROL;
				17: f = pin_mux_pkg::FUNC_PORT1_POWER_CONTROL;
				18: f = pin_mux_pkg::FUNC_BRIDGE_MASTER_CLOCK;
				19: f = pin_mux_pkg::FUNC_MICROPHONE_SENSE;
				20: f = pin_mux_pkg::FUNC_FLASH_SELECT_N;
				21: f = pin_mux_pkg::FUNC_FLASH_CLOCK;
				22: f = pin_mux_pkg::FUNC_FLASH_IO0;
				23: f = pin_mux_pkg::FUNC_FLASH_IO1;
				24: f = pin_mux_pkg::FUNC_FLASH_IO2;
				25: f = pin_mux_pkg::FUNC_FLASH_IO3;
				26: f = pin_mux_pkg::FUNC_TARGET_SERIAL_CLOCK;
				27: f = pin_mux_pkg::FUNC_TARGET_SERIAL_LINE;
				28: f = pin_mux_pkg::FUNC_PORT6_POWER_CONTROL;
				30: f = pin_mux_pkg::FUNC_UPSTREAM_POWER_SENSE;
				31: f = pin_mux_pkg::FUNC_BRIDGE_MASTER_LINE;
				default: f = pin_mux_pkg::FUNC_NONE;
			endcase
		end
		return f;
	endfunction

	// Functions that never drive the pin: no function, and those that only sense it.
	function automatic logic input_only(input pin_mux_pkg::func_t f);
		return (f == pin_mux_pkg::FUNC_NONE) ||
		       (f == pin_mux_pkg::FUNC_AUDIO_SERIAL_IN) ||
		       (f == pin_mux_pkg::FUNC_MICROPHONE_SENSE) ||
		       (f == pin_mux_pkg::FUNC_UPSTREAM_POWER_SENSE);
	endfunction

	mux_table_if              table_bus ();
	pin_mux_pkg::mode_t       mode;
	pin_mux_pkg::func_t       select_function;
	pin_mux_pkg::func_t       pin_func [pin_mux_pkg::NUM_PINS];
	logic [pin_mux_pkg::PIN_NUM_W-1:0] select_index;
	logic [pin_mux_pkg::PIN_NUM_W-1:0] readback_index;
	logic [pin_mux_pkg::NUM_PINS-1:0]  pin_in_meta_q;
	logic [pin_mux_pkg::NUM_PINS-1:0]  pin_in_q;
	logic [pin_mux_pkg::NUM_PINS-1:0]  pin_out_q;
	logic [pin_mux_pkg::NUM_PINS-1:0]  pin_out_d;
	logic [pin_mux_pkg::NUM_PINS-1:0]  pin_oe_q;
	logic [pin_mux_pkg::NUM_PINS-1:0]  pin_oe_d;
	logic [pin_mux_pkg::NUM_FUNC-1:0]  func_in_q;
	logic [pin_mux_pkg::NUM_FUNC-1:0]  func_in_d;

	// Straps are synchronised, decoded and held in their own module.
	strap_mode_latch u_strap_mode_latch (
		.i_clock        (i_clock),
		.i_resetn       (i_resetn),
		.i_clock_enable (i_clock_enable),
		.i_strap1_level (i_mode_strap1_level),
		.i_strap2_level (i_mode_strap2_level),
		.o_mode         (mode)
	);

	// Override table written from the configuration port.
	pin_override_table u_pin_override_table (
		.i_clock        (i_clock),
		.i_resetn       (i_resetn),
		.i_clock_enable (i_clock_enable),
		.bus            (table_bus.table_side)
	);

	// Pin numbers become table indices; codes past the last function mean none.
	always_comb begin
		select_index   = i_select_pin - pin_mux_pkg::PIN_NUM_W'(pin_mux_pkg::FIRST_PIN);
		readback_index = i_readback_pin - pin_mux_pkg::PIN_NUM_W'(pin_mux_pkg::FIRST_PIN);
		if (i_select_function < pin_mux_pkg::FUNC_W'(pin_mux_pkg::NUM_FUNC)) begin
			select_function = pin_mux_pkg::func_t'(i_select_function);
		end else begin
			select_function = pin_mux_pkg::FUNC_NONE;
		end
	end

	// Writes outside pins three to thirty-one are dropped by the range check.
	assign table_bus.write_en = i_select_write &&
	                            i_select_pin >= pin_mux_pkg::PIN_NUM_W'(pin_mux_pkg::FIRST_PIN);
	assign table_bus.write_index    = select_index;
	assign table_bus.write_override = i_select_override;
	assign table_bus.write_func     = select_function;
	assign table_bus.read_index     = (i_readback_pin >= pin_mux_pkg::PIN_NUM_W'(pin_mux_pkg::FIRST_PIN))
	                                  ? readback_index : pin_mux_pkg::PIN_NUM_W'(pin_mux_pkg::NUM_PINS);

	// Effective function of each pin: the override when set, otherwise the strap default.
	always_comb begin
		for (int i = 0; i < pin_mux_pkg::NUM_PINS; i++) begin
			if (table_bus.override_valid[i]) begin
				pin_func[i] = table_bus.override_func[i];
			end else begin
				pin_func[i] = default_function(i + pin_mux_pkg::FIRST_PIN, mode);
			end
		end
	end

	// Next pin drive and sensed function inputs.
	always_comb begin
		pin_out_d = pin_mux_pkg::PINS_RESET;
		pin_oe_d  = pin_mux_pkg::PINS_RESET;
		func_in_d = pin_mux_pkg::FUNCS_RESET;
		for (int i = 0; i < pin_mux_pkg::NUM_PINS; i++) begin
			if (!input_only(pin_func[i])) begin
				pin_out_d[i] = i_function_out[pin_func[i]];
				pin_oe_d[i]  = i_function_oe[pin_func[i]];
			end
			if (pin_func[i] != pin_mux_pkg::FUNC_NONE) begin
				func_in_d[pin_func[i]] = func_in_d[pin_func[i]] | pin_in_q[i];
			end
		end
	end

	// Pins sampled through two flops; drive and sensed values come from flops.
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			pin_in_meta_q <= pin_mux_pkg::PINS_RESET;
			pin_in_q      <= pin_mux_pkg::PINS_RESET;
			pin_out_q     <= pin_mux_pkg::PINS_RESET;
			pin_oe_q      <= pin_mux_pkg::PINS_RESET;
			func_in_q     <= pin_mux_pkg::FUNCS_RESET;
		end else if (i_clock_enable) begin
			pin_in_meta_q <= i_programmable_pins;
			pin_in_q      <= pin_in_meta_q;
			pin_out_q     <= pin_out_d;
			pin_oe_q      <= pin_oe_d;
			func_in_q     <= func_in_d;
		end
	end

	assign o_programmable_pins      = pin_out_q;
	assign o_programmable_pins_oe   = pin_oe_q;
	assign o_function_in            = func_in_q;
	assign o_readback_function      = table_bus.read_func;
	assign o_readback_override      = table_bus.read_override;
	assign o_mode_captured          = (mode != pin_mux_pkg::MODE_WAIT);
	assign o_mode_config3           = (mode == pin_mux_pkg::MODE_CONFIG3);
	// High level on the sense pin means a microphone is plugged in.
	assign o_microphone_present     = func_in_q[pin_mux_pkg::FUNC_MICROPHONE_SENSE];
	assign o_upstream_power_present = func_in_q[pin_mux_pkg::FUNC_UPSTREAM_POWER_SENSE];

endmodule // strap_selected_pin_function_mux

// [verif/board_model.sv]
`timescale 1ns/1ps

// Board strap resistors and the peripherals that share the programmable pins.
module board_model (
	input  wire logic                              i_use_reserved,
	input  wire logic [pin_mux_pkg::LEVEL_W-1:0]   i_reserved_strap2,
	input  wire logic [pin_mux_pkg::LEVEL_W-1:0]   i_reserved_strap1,
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0]  i_peripheral_levels,
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0]  i_pin_drive,
	input  wire logic [pin_mux_pkg::NUM_PINS-1:0]  i_pin_drive_oe,
	output logic      [pin_mux_pkg::LEVEL_W-1:0]   o_strap2_level,
	output logic      [pin_mux_pkg::LEVEL_W-1:0]   o_strap1_level,
	output logic      [pin_mux_pkg::NUM_PINS-1:0]  o_pin_levels
);
	// Fits the documented pair unless a reserved pair is asked for on purpose.
	// The spare mode strap is tied low on the board, so it has no wire here.
	always_comb begin
		o_strap2_level = i_use_reserved ? i_reserved_strap2 : pin_mux_pkg::LEVEL_PD_200K;
		o_strap1_level = i_use_reserved ? i_reserved_strap1 : pin_mux_pkg::LEVEL_PD_10K;
	end

	// Where the hub drives a pin it wins; elsewhere the attached device sets the level.
	assign o_pin_levels = (i_pin_drive & i_pin_drive_oe) | (i_peripheral_levels & ~i_pin_drive_oe);
endmodule // board_model

// [verif/pin_mux_asserts.sv]
`timescale 1ns/1ps

// Watches the top ports for strap capture, default mapping and override timing.
module pin_mux_asserts (
	input wire logic                              i_clock,
	input wire logic                              i_resetn,
	input wire logic                              i_clock_enable,
	input wire logic [pin_mux_pkg::LEVEL_W-1:0]   i_mode_strap1_level,
	input wire logic [pin_mux_pkg::LEVEL_W-1:0]   i_mode_strap2_level,
	input wire logic [pin_mux_pkg::NUM_PINS-1:0]  i_programmable_pins,
	input wire logic [pin_mux_pkg::NUM_PINS-1:0]  o_programmable_pins,
	input wire logic [pin_mux_pkg::NUM_PINS-1:0]  o_programmable_pins_oe,
	input wire logic [pin_mux_pkg::NUM_FUNC-1:0]  i_function_out,
	input wire logic [pin_mux_pkg::NUM_FUNC-1:0]  i_function_oe,
	input wire logic [pin_mux_pkg::NUM_FUNC-1:0]  o_function_in,
	input wire logic                              i_select_write,
	input wire logic [pin_mux_pkg::PIN_NUM_W-1:0] i_select_pin,
	input wire logic                              i_select_override,
	input wire logic [pin_mux_pkg::FUNC_W-1:0]    i_select_function,
	input wire logic [pin_mux_pkg::PIN_NUM_W-1:0] i_readback_pin,
	input wire logic [pin_mux_pkg::FUNC_W-1:0]    o_readback_function,
	input wire logic                              o_readback_override,
	input wire logic                              o_mode_captured,
	input wire logic                              o_mode_config3,
	input wire logic                              o_microphone_present,
	input wire logic                              o_upstream_power_present
);
	logic any_write_q;
	logic any_write_d;

	// Remembers whether any select write was made while enabled since reset, refused pins included.
	always_comb begin
		any_write_d = any_write_q | (i_select_write & i_clock_enable);
	end
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			any_write_q <= 1'b0;
		end else begin
			any_write_q <= any_write_d;
		end
	end

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_resetn);

	// An override write whose entry is also the one being read back.
	sequence s_override_write;
		i_select_write && i_clock_enable && i_select_pin >= 5'h03 && i_select_override
			&& i_select_function < 5'h1B && i_readback_pin == i_select_pin;
	endsequence
	sequence s_quiet_cycle;
		i_clock_enable && !i_select_write && $stable(i_readback_pin);
	endsequence

	a_captured_sticky: assert property (o_mode_captured |=> o_mode_captured)
		else $error("mode captured flag fell");
	a_mode_held: assert property (o_mode_captured |=> $stable(o_mode_config3))
		else $error("latched mode changed");
	a_capture_timing: assert property ($rose(i_resetn) |->
		!o_mode_captured [*3] ##1 o_mode_captured)
		else $error("mode not captured on the third edge after release");
	a_config3_decode: assert property ($rose(o_mode_captured) |->
		o_mode_config3 == ($past(i_mode_strap2_level, 3) == pin_mux_pkg::LEVEL_PD_200K
		&& $past(i_mode_strap1_level, 3) == pin_mux_pkg::LEVEL_PD_10K))
		else $error("strap pair decoded wrongly");
	a_reserved_quiet: assert property (o_mode_captured && !o_mode_config3 && !any_write_q
		|-> o_programmable_pins_oe == 29'h0000_0000)
		else $error("reserved mode drives a pin");
	a_input_pins_quiet: assert property (o_mode_config3 && !any_write_q
		|-> (o_programmable_pins_oe & 29'h0C01_0061) == 29'h0000_0000)
		else $error("unused or input pin drives");
	a_default_drive: assert property (o_mode_config3 && $past(o_mode_config3)
		&& $past(i_clock_enable) && !any_write_q
		|-> o_programmable_pins_oe[1] == $past(i_function_oe[2])
		&& o_programmable_pins[28] == $past(i_function_out[16]))
		else $error("default pin drive wrong");
	a_readback_entry: assert property (s_override_write ##1 s_quiet_cycle |=>
		o_readback_override && o_readback_function == $past(i_select_function, 2))
		else $error("readback does not show written entry");
	a_mic_sense: assert property ((o_mode_config3 && i_clock_enable && !any_write_q
		&& $stable(i_programmable_pins[16])) [*5] |-> o_microphone_present == i_programmable_pins[16])
		else $error("microphone sense wrong");
	a_upstream_sense: assert property ((o_mode_config3 && i_clock_enable && !any_write_q
		&& $stable(i_programmable_pins[27])) [*5]
		|-> o_upstream_power_present == i_programmable_pins[27])
		else $error("upstream power sense wrong");
endmodule // pin_mux_asserts

bind strap_selected_pin_function_mux pin_mux_asserts i_pin_mux_asserts (
	.i_clock(i_clock), .i_resetn(i_resetn), .i_clock_enable(i_clock_enable),
	.i_mode_strap1_level(i_mode_strap1_level), .i_mode_strap2_level(i_mode_strap2_level),
	.i_programmable_pins(i_programmable_pins), .o_programmable_pins(o_programmable_pins),
	.o_programmable_pins_oe(o_programmable_pins_oe), .i_function_out(i_function_out),
	.i_function_oe(i_function_oe), .o_function_in(o_function_in),
	.i_select_write(i_select_write), .i_select_pin(i_select_pin),
	.i_select_override(i_select_override), .i_select_function(i_select_function),
	.i_readback_pin(i_readback_pin), .o_readback_function(o_readback_function),
	.o_readback_override(o_readback_override), .o_mode_captured(o_mode_captured),
	.o_mode_config3(o_mode_config3), .o_microphone_present(o_microphone_present),
	.o_upstream_power_present(o_upstream_power_present));

// [verif/tb.sv]
`timescale 1ns/1ps

module tb;
	logic        clock, resetn, enable, use_res, sel_wr, sel_ovr, rb_ovr;
	logic        captured, cfg3, mic, ups;
	logic [2:0]  res2, res1, strap2, strap1;
	logic [28:0] ext, pins, pins_out, pins_oe;
	logic [26:0] fout, foe, fin;
	logic [4:0]  sel_pin, sel_func, rb_pin, rb_func;
	int          miscompares = 0;
	int          n_checks = 0;
	int          cycles = 0;
	localparam logic [4:0] DEF_FUNC [29] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h00, 5'h00,
		5'h0C, 5'h0D, 5'h0E, 5'h0A, 5'h09, 5'h08, 5'h07, 5'h06, 5'h0F, 5'h11, 5'h12, 5'h13,
		5'h14, 5'h15, 5'h16, 5'h17, 5'h18, 5'h19, 5'h0B, 5'h00, 5'h1A, 5'h10};

	strap_selected_pin_function_mux i_strap_selected_pin_function_mux (
		.i_clock(clock), .i_resetn(resetn), .i_clock_enable(enable),
		.i_mode_strap1_level(strap1), .i_mode_strap2_level(strap2),
		.i_programmable_pins(pins), .o_programmable_pins(pins_out),
		.o_programmable_pins_oe(pins_oe), .i_function_out(fout), .i_function_oe(foe),
		.o_function_in(fin), .i_select_write(sel_wr), .i_select_pin(sel_pin),
		.i_select_override(sel_ovr), .i_select_function(sel_func), .i_readback_pin(rb_pin),
		.o_readback_function(rb_func), .o_readback_override(rb_ovr), .o_mode_captured(captured),
		.o_mode_config3(cfg3), .o_microphone_present(mic), .o_upstream_power_present(ups));
	board_model i_board_model (
		.i_use_reserved(use_res), .i_reserved_strap2(res2), .i_reserved_strap1(res1),
		.i_peripheral_levels(ext), .i_pin_drive(pins_out), .i_pin_drive_oe(pins_oe),
		.o_strap2_level(strap2), .o_strap1_level(strap1), .o_pin_levels(pins));

	// Free-running clock at 20 MHz.
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// Cuts a hung run short.
	always @(posedge clock) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			finish_test();
		end
	end

	task automatic check(input logic ok, input string what);
		n_checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic reset_dut(input logic rsv, input logic [5:0] pair);
		int n;
		use_res = rsv;
		{res2, res1} = pair;
		resetn = 1'b0;
		repeat (4) @(negedge clock);
		resetn = 1'b1;
		n = 0;
		while (captured !== 1'b1 && n < 20) begin
			@(negedge clock);
			n++;
		end
		@(negedge clock);
		check(captured === 1'b1, "mode not captured");
	endtask

	task automatic wr(input logic [4:0] pin, input logic ovr, input logic [4:0] func);
		sel_wr = 1'b1;
		sel_pin = pin;
		sel_ovr = ovr;
		sel_func = func;
		@(negedge clock);
	endtask

	// Every pin of the bank against the default table, then inputs and strap hold.
	task automatic default_map();
		logic [4:0] f;
		logic       inp;
		logic       lv;
		reset_dut(1'b0, 6'h00);
		check(cfg3 === 1'b1, "documented pair not decoded");
		for (int k = 0; k < 2; k++) begin
			fout = k[0] ? 27'h2AA_AAAA : 27'h555_5555;
			foe = ~fout;
			@(negedge clock);
			for (int i = 0; i < 29; i++) begin
				f = DEF_FUNC[i];
				inp = f inside {5'h00, 5'h01, 5'h11, 5'h1A};
				check(pins_oe[i] === (inp ? 1'b0 : foe[f]), "default enable");
				if (!inp) check(pins_out[i] === fout[f], "default drive");
			end
		end
		for (int k = 0; k < 2; k++) begin
			lv = k[0];
			ext = {29{lv}};
			repeat (5) @(negedge clock);
			check(mic === lv && fin[17] === lv, "microphone sense");
			check(ups === lv && fin[26] === lv && fin[1] === lv, "input functions");
		end
		use_res = 1'b1;
		{res2, res1} = 6'h09;
		repeat (10) @(negedge clock);
		check(captured === 1'b1 && cfg3 === 1'b1, "straps not held");
	endtask

	// Reserved strap pairs leave every pin undriven.
	task automatic reserved_codes();
		logic [5:0] pairs [6] = '{6'h00, 6'h0A, 6'h03, 6'h12, 6'h2C, 6'h10};
		foe = 27'h7FF_FFFF;
		for (int i = 0; i < 6; i++) begin
			reset_dut(1'b1, pairs[i]);
			repeat (3) @(negedge clock);
			check(captured === 1'b1 && cfg3 === 1'b0, "reserved pair decoded");
			check(pins_oe === 29'h0000_0000, "reserved mode drives");
		end
	endtask

	// Override writes, back to back, refused pins and the return to defaults.
	task automatic overrides();
		reset_dut(1'b0, 6'h00);
		fout = 27'h000_0004;
		foe = 27'h7FF_FFFF;
		rb_pin = 5'h08;
		wr(5'h08, 1'b1, 5'h02);
		sel_wr = 1'b0;
		@(negedge clock);
		check(pins_oe[5] === 1'b1 && pins_out[5] === 1'b1, "override not driven");
		check(pins_oe[1] === 1'b1 && pins_out[1] === 1'b1, "unchanged pin moved");
		check(rb_func === 5'h02 && rb_ovr === 1'b1, "readback entry");
		wr(5'h04, 1'b1, 5'h1F);
		wr(5'h02, 1'b1, 5'h02);
		sel_wr = 1'b0;
		rb_pin = 5'h02;
		@(negedge clock);
		check(pins_oe[1] === 1'b0 && pins_oe[5] === 1'b1, "back to back writes");
		check(rb_func === 5'h00 && rb_ovr === 1'b0, "refused pin stored");
		wr(5'h04, 1'b0, 5'h00);
		sel_wr = 1'b0;
		@(negedge clock);
		check(pins_oe[1] === 1'b1, "default not restored");
		enable = 1'b0;
		wr(5'h09, 1'b1, 5'h02);
		sel_wr = 1'b0;
		enable = 1'b1;
		repeat (2) @(negedge clock);
		check(pins_oe[6] === 1'b0, "write taken while frozen");
	endtask

	// Main sequence.
	initial begin
		resetn = 1'b0;
		enable = 1'b1;
		use_res = 1'b0;
		res2 = 3'h0;
		res1 = 3'h0;
		ext = 29'h0000_0000;
		fout = 27'h000_0000;
		foe = 27'h000_0000;
		sel_wr = 1'b0;
		sel_pin = 5'h00;
		sel_ovr = 1'b0;
		sel_func = 5'h00;
		rb_pin = 5'h00;
		default_map();
		reserved_codes();
		overrides();
		finish_test();
	end
endmodule // tb
